// ===== npo_cfg.svh
// How it works
// - nfc-a emulation: frame delay shortened by trim
// - poll reply bit: 0 auto, 1 suppressed
// - anticollision bit: 0 auto, 1 disabled
// - automatic replies off: frames through fifo only
// - subcarrier stream: select gives fc/64 to fc/8
// - bpsk stream: only code 00, fc/16
// - pulse count 1,2 (both bpsk only),4,8
// - tx period fc/128 to fc/16, 1xx reserved
// - crc skip bit: 0 check, 1 skip
// - no crc after reqa/wupa or during anticollision
// - id size: 4 or 7 bytes, 1x reserved
// - phase clock shift: 0 or 90 degrees
// - iso-a and type 1: correlator only
// - iso-b: correlator or coherent pulse reception
// - stream: correlator only for 01/11, else pulse
// - n value feeds initial field-on command
`ifndef NPO_CFG_SVH
`define NPO_CFG_SVH

`define NPO_IDX_PTO 6'h08
`define NPO_IDX_SMO 6'h09
`define NPO_IDX_AUX 6'h0a
`define NPO_ADDR_PTO {`NPO_IDX_PTO, 2'b00}
`define NPO_ADDR_SMO {`NPO_IDX_SMO, 2'b00}
`define NPO_ADDR_AUX {`NPO_IDX_AUX, 2'b00}

`define NPO_PTO_FDEL_LSB 4
`define NPO_PTO_POLL_OFF 2
`define NPO_PTO_ANTI_OFF 0
`define NPO_SMO_SCF_LSB 5
`define NPO_SMO_SCP_LSB 3
`define NPO_SMO_STX_LSB 0
`define NPO_AUX_NOCRC 7
`define NPO_AUX_ID_LSB 4
`define NPO_AUX_PCS 3
`define NPO_AUX_PULSE 2
`define NPO_AUX_N_LSB 0

`define NPO_PTO_MASK 8'hf5
`define NPO_SMO_MASK 8'h7f
`define NPO_AUX_MASK 8'hbf
`define NPO_PTO_RST 8'h00
`define NPO_SMO_RST 8'h00
`define NPO_AUX_RST 8'h00

`define NPO_FC_PERIOD_NS 50
`define NPO_TRIM_STEP_NS 50
`define NPO_TRIM_STEP_CYC (`NPO_TRIM_STEP_NS / `NPO_FC_PERIOD_NS)

`endif

// ===== npo_pkg.sv
`default_nettype none
package npo_pkg;
  typedef enum logic [2:0] {
    NPO_MODE_ISO_A,
    NPO_MODE_ISO_B,
    NPO_MODE_TYPE1,
    NPO_MODE_STREAM_SUB,
    NPO_MODE_STREAM_BPSK,
    NPO_MODE_OTHER
  } npo_mode_t;
  typedef enum logic {
    NPO_CRC_IDLE,
    NPO_CRC_WAIT_RX
  } npo_crc_state_t;
  typedef enum logic {
    NPO_FDT_IDLE,
    NPO_FDT_COUNT
  } npo_fdt_state_t;
endpackage : npo_pkg
`default_nettype wire

// ===== npo_div_if.sv
`default_nettype none
interface npo_div_if;
  logic en;
  logic [2:0] log2div;
  logic tick;
  modport ctl (output en, output log2div, input tick);
  modport div (input en, input log2div, output tick);
endinterface : npo_div_if
`default_nettype wire

// ===== npo_divider.sv
`default_nettype none
module npo_divider #(
  parameter int CNT_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  npo_div_if.div d
);
  if (CNT_W < 3 || CNT_W > 7) begin : g_bad_cnt_w
    $error("npo_divider: CNT_W out of range");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic tick_ff;
  wire [CNT_W-1:0] top_cnt = ~({CNT_W{1'b1}} << d.log2div);
  wire at_top = (cnt_ff == top_cnt);

  // counter restarts whenever disabled so a rate enabled afresh starts on a full period; a rate change while enabled does not restart it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= (!d.en || at_top) ? '0 : cnt_ff + 1'b1;
      tick_ff <= d.en && at_top;
    end
  end
  assign d.tick = tick_ff;
endmodule : npo_divider
`default_nettype wire

// ===== npo_fdt_timer.sv
`include "npo_cfg.svh"
`default_nettype none
module npo_fdt_timer #(
  parameter int FDT_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [FDT_W-1:0] nominal,
  input wire logic [3:0] trim,
  output logic expire,
  output logic busy
);
  if (FDT_W < 5) begin : g_bad_fdt_w
    $error("npo_fdt_timer: FDT_W too small");
  end

  npo_pkg::npo_fdt_state_t state_ff;
  logic [FDT_W-1:0] cnt_ff;
  logic expire_ff;
  wire [FDT_W-1:0] trim_cyc = FDT_W'(trim) * FDT_W'(`NPO_TRIM_STEP_CYC);
  wire [FDT_W-1:0] shortened = (nominal > trim_cyc) ? nominal - trim_cyc : FDT_W'(1);
  wire [FDT_W-1:0] nxt_cnt = (state_ff == npo_pkg::NPO_FDT_IDLE) ? shortened : cnt_ff - 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= npo_pkg::NPO_FDT_IDLE;
      cnt_ff <= '0;
      expire_ff <= 1'b0;
    end else begin
      expire_ff <= 1'b0;
      case (state_ff)
        npo_pkg::NPO_FDT_IDLE: begin
          if (start) begin
            cnt_ff <= nxt_cnt;
            state_ff <= npo_pkg::NPO_FDT_COUNT;
          end
        end
        npo_pkg::NPO_FDT_COUNT: begin
          cnt_ff <= nxt_cnt;
          if (cnt_ff == FDT_W'(1)) begin
            expire_ff <= 1'b1;
            state_ff <= npo_pkg::NPO_FDT_IDLE;
          end
        end
        default: state_ff <= npo_pkg::NPO_FDT_IDLE;
      endcase
    end
  end
  assign expire = expire_ff;
  assign busy = (state_ff == npo_pkg::NPO_FDT_COUNT);
endmodule : npo_fdt_timer
`default_nettype wire

// ===== npo_option_regs.sv
`include "npo_cfg.svh"
`default_nettype none
module npo_option_regs #(
  parameter int FDT_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol context from the surrounding control logic
  input wire logic [2:0] proto_mode,
  input wire logic ce_nfca,
  input wire logic fdt_start,
  input wire logic [FDT_W-1:0] fdt_nominal,
  input wire logic anticoll_req,
  input wire logic poll_req,
  input wire logic reqa_wupa_sent,
  input wire logic anticoll_bit,
  input wire logic rx_end,
  input wire logic field_on_cmd,
  // decoded controls
  output logic fdt_expire,
  output logic auto_anticoll_go,
  output logic auto_poll_reply_go,
  output logic target_frame_to_fifo,
  output logic target_via_fifo,
  output logic crc_check_en,
  output logic [2:0] nfcid1_bytes,
  output logic phase_clock_shift,
  output logic rx_use_pulse,
  output logic subcarrier_tick,
  output logic report_tick,
  output logic tx_period_tick,
  output logic cfg_reserved_err,
  output logic rx_sel_na,
  output logic field_on_go,
  output logic [1:0] field_on_n
);
  if (FDT_W < 5 || FDT_W > 24) begin : g_bad_fdt_w
    $error("npo_option_regs: FDT_W out of range");
  end

  // ---------------- apb register access ----------------
  logic [7:0] pto_ff;
  logic [7:0] smo_ff;
  logic [7:0] aux_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  wire setup = psel && !penable;
  wire access = psel && penable && pready_ff;
  wire hit_pto = (paddr == `NPO_ADDR_PTO);
  wire hit_smo = (paddr == `NPO_ADDR_SMO);
  wire hit_aux = (paddr == `NPO_ADDR_AUX);
  wire hit_any = hit_pto || hit_smo || hit_aux;
  wire wr_ok = access && pwrite && hit_any;

  // reserved bits are never stored, so they reset and read as zero
  wire [7:0] nxt_pto = pwdata[7:0] & `NPO_PTO_MASK;
  wire [7:0] nxt_smo = pwdata[7:0] & `NPO_SMO_MASK;
  wire [7:0] nxt_aux = pwdata[7:0] & `NPO_AUX_MASK;
  wire [7:0] rd_sel = hit_pto ? pto_ff : hit_smo ? smo_ff : hit_aux ? aux_ff : 8'h00;
  wire [31:0] nxt_prdata = {24'h000000, rd_sel};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      // answer is ready in the first access cycle: no wait states
      pready_ff <= setup;
      pslverr_ff <= setup && !hit_any;
      if (setup) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pto_ff <= `NPO_PTO_RST;
      smo_ff <= `NPO_SMO_RST;
      aux_ff <= `NPO_AUX_RST;
    end else if (wr_ok) begin
      if (hit_pto) pto_ff <= nxt_pto;
      if (hit_smo) smo_ff <= nxt_smo;
      if (hit_aux) aux_ff <= nxt_aux;
    end
  end

  // ---------------- field decode ----------------
  wire [3:0] fdel = pto_ff[`NPO_PTO_FDEL_LSB +: 4];
  wire poll_off = pto_ff[`NPO_PTO_POLL_OFF];
  wire anti_off = pto_ff[`NPO_PTO_ANTI_OFF];
  wire [1:0] scf = smo_ff[`NPO_SMO_SCF_LSB +: 2];
  wire [1:0] scp = smo_ff[`NPO_SMO_SCP_LSB +: 2];
  wire [2:0] stx = smo_ff[`NPO_SMO_STX_LSB +: 3];
  wire no_crc = aux_ff[`NPO_AUX_NOCRC];
  wire [1:0] id_size = aux_ff[`NPO_AUX_ID_LSB +: 2];
  wire pcs = aux_ff[`NPO_AUX_PCS];
  wire pulse_sel = aux_ff[`NPO_AUX_PULSE];
  wire [1:0] n_val = aux_ff[`NPO_AUX_N_LSB +: 2];

  wire is_iso_a = (proto_mode == npo_pkg::NPO_MODE_ISO_A);
  wire is_iso_b = (proto_mode == npo_pkg::NPO_MODE_ISO_B);
  wire is_type1 = (proto_mode == npo_pkg::NPO_MODE_TYPE1);
  wire is_sub = (proto_mode == npo_pkg::NPO_MODE_STREAM_SUB);
  wire is_bpsk = (proto_mode == npo_pkg::NPO_MODE_STREAM_BPSK);
  wire is_stream = is_sub || is_bpsk;

  // ---------------- frame delay trim ----------------
  // trim only acts in nfc-a card emulation; elsewhere the nominal delay runs
  wire [3:0] fdt_trim = ce_nfca ? fdel : 4'h0;
  logic fdt_expire_w;

  npo_fdt_timer #(
    .FDT_W(FDT_W)
  ) u_fdt (
    .pclk(pclk),
    .presetn(presetn),
    .start(fdt_start),
    .nominal(fdt_nominal),
    .trim(fdt_trim),
    .expire(fdt_expire_w),
    .busy()
  );

  // ---------------- automatic target replies ----------------
  logic auto_anticoll_go_ff;
  logic auto_poll_reply_go_ff;
  logic target_frame_to_fifo_ff;
  logic target_via_fifo_ff;

  wire anti_go = anticoll_req && !anti_off;
  wire poll_go = poll_req && !poll_off;
  // a suppressed request is handed to the host instead of being answered
  wire to_fifo = (anticoll_req && anti_off) || (poll_req && poll_off);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_anticoll_go_ff <= 1'b0;
      auto_poll_reply_go_ff <= 1'b0;
      target_frame_to_fifo_ff <= 1'b0;
      target_via_fifo_ff <= 1'b0;
    end else begin
      auto_anticoll_go_ff <= anti_go;
      auto_poll_reply_go_ff <= poll_go;
      target_frame_to_fifo_ff <= to_fifo;
      target_via_fifo_ff <= anti_off || poll_off;
    end
  end

  // ---------------- receive crc handling ----------------
  npo_pkg::npo_crc_state_t crc_state_ff;
  npo_pkg::npo_crc_state_t nxt_crc_state;
  logic crc_check_en_ff;

  // a new reqa/wupa in the same cycle as rx_end keeps the window open
  always_comb begin
    nxt_crc_state = crc_state_ff;
    case (crc_state_ff)
      npo_pkg::NPO_CRC_IDLE: begin
        if (reqa_wupa_sent) nxt_crc_state = npo_pkg::NPO_CRC_WAIT_RX;
      end
      npo_pkg::NPO_CRC_WAIT_RX: begin
        if (rx_end && !reqa_wupa_sent) nxt_crc_state = npo_pkg::NPO_CRC_IDLE;
      end
      default: nxt_crc_state = npo_pkg::NPO_CRC_IDLE;
    endcase
  end

  wire crc_forced_off = (nxt_crc_state == npo_pkg::NPO_CRC_WAIT_RX) || anticoll_bit;
  wire nxt_crc_check_en = !no_crc && !crc_forced_off;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_state_ff <= npo_pkg::NPO_CRC_IDLE;
      crc_check_en_ff <= 1'b1;
    end else begin
      crc_state_ff <= nxt_crc_state;
      crc_check_en_ff <= nxt_crc_check_en;
    end
  end

  // ---------------- id size, phase clock, rx path ----------------
  logic [2:0] nfcid1_bytes_ff;
  logic phase_clock_shift_ff;
  logic rx_use_pulse_ff;
  logic rx_sel_na_ff;

  // reserved id codes fall back to 4 bytes and are reported
  wire [2:0] nxt_id_bytes = (id_size == 2'b01) ? 3'h7 : 3'h4;
  wire id_rsvd = id_size[1];

  wire corr_allowed_stream = (scf == 2'b01) && (scp == 2'b11);
  wire nxt_use_pulse = (is_iso_a || is_type1) ? 1'b0 :
                       is_iso_b ? pulse_sel :
                       is_stream ? (pulse_sel || !corr_allowed_stream) : pulse_sel;
  wire nxt_sel_na = ((is_iso_a || is_type1) && pulse_sel) ||
                    (is_stream && !corr_allowed_stream && !pulse_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nfcid1_bytes_ff <= 3'h4;
      phase_clock_shift_ff <= 1'b0;
      rx_use_pulse_ff <= 1'b0;
      rx_sel_na_ff <= 1'b0;
    end else begin
      nfcid1_bytes_ff <= nxt_id_bytes;
      phase_clock_shift_ff <= pcs;
      rx_use_pulse_ff <= nxt_use_pulse;
      rx_sel_na_ff <= nxt_sel_na;
    end
  end

  // ---------------- stream mode timing ----------------
  npo_div_if sc_if ();
  npo_div_if tx_if ();

  // subcarrier divide: fc/64, /32, /16, /8; bpsk only defines fc/16
  wire [2:0] sc_log2 = is_bpsk ? 3'h4 : 3'(3'h6 - {1'b0, scf});
  wire bpsk_rsvd = is_bpsk && (scf != 2'b00);
  wire scp_rsvd = is_sub && !scp[1];
  wire stx_rsvd = is_stream && stx[2];
  // reserved codes stop the rate instead of producing an undefined one
  assign sc_if.en = is_stream && !bpsk_rsvd && !scp_rsvd;
  assign sc_if.log2div = sc_log2;
  assign tx_if.en = is_stream && !stx_rsvd;
  assign tx_if.log2div = 3'(3'h7 - stx[1:0]);

  npo_divider #(
    .CNT_W(7)
  ) u_sc_div (
    .pclk(pclk),
    .presetn(presetn),
    .d(sc_if.div)
  );

  npo_divider #(
    .CNT_W(7)
  ) u_tx_div (
    .pclk(pclk),
    .presetn(presetn),
    .d(tx_if.div)
  );

  logic [2:0] pulse_cnt_ff;
  logic report_tick_ff;
  logic cfg_reserved_err_ff;
  wire [2:0] pulse_last = 3'((4'h1 << scp) - 4'h1);
  wire pulse_wrap = sc_if.tick && (pulse_cnt_ff == pulse_last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_ff <= 3'h0;
      report_tick_ff <= 1'b0;
    end else begin
      report_tick_ff <= pulse_wrap;
      if (!sc_if.en || pulse_wrap) begin
        pulse_cnt_ff <= 3'h0;
      end else if (sc_if.tick) begin
        pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
      end
    end
  end

  wire nxt_rsvd_err = bpsk_rsvd || scp_rsvd || stx_rsvd || id_rsvd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reserved_err_ff <= 1'b0;
    end else begin
      cfg_reserved_err_ff <= nxt_rsvd_err;
    end
  end

  // ---------------- initial field-on ----------------
  logic field_on_go_ff;
  logic [1:0] field_on_n_ff;

  // n is captured with the command so a later write cannot disturb it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_on_go_ff <= 1'b0;
      field_on_n_ff <= 2'b00;
    end else begin
      field_on_go_ff <= field_on_cmd;
      if (field_on_cmd) begin
        field_on_n_ff <= n_val;
      end
    end
  end

  // ---------------- outputs ----------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fdt_expire = fdt_expire_w;
  assign auto_anticoll_go = auto_anticoll_go_ff;
  assign auto_poll_reply_go = auto_poll_reply_go_ff;
  assign target_frame_to_fifo = target_frame_to_fifo_ff;
  assign target_via_fifo = target_via_fifo_ff;
  assign crc_check_en = crc_check_en_ff;
  assign nfcid1_bytes = nfcid1_bytes_ff;
  assign phase_clock_shift = phase_clock_shift_ff;
  assign rx_use_pulse = rx_use_pulse_ff;
  assign rx_sel_na = rx_sel_na_ff;
  assign subcarrier_tick = sc_if.tick;
  assign tx_period_tick = tx_if.tick;
  assign report_tick = report_tick_ff;
  assign cfg_reserved_err = cfg_reserved_err_ff;
  assign field_on_go = field_on_go_ff;
  assign field_on_n = field_on_n_ff;
endmodule : npo_option_regs
`default_nettype wire

// ===== npo_option_regs_assertions.sv
`default_nettype none
module npo_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic poll_req,
  input wire logic anticoll_req,
  input wire logic reqa_wupa_sent,
  input wire logic field_on_cmd,
  input wire logic auto_poll_reply_go,
  input wire logic auto_anticoll_go,
  input wire logic target_frame_to_fifo,
  input wire logic crc_check_en,
  input wire logic field_on_go
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && !penable |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no zero wait answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held too long");
  property p_err; pready |-> pslverr == !(paddr inside {8'h20, 8'h24, 8'h28}); endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_poll; poll_req && !anticoll_req |=> auto_poll_reply_go ^ target_frame_to_fifo; endproperty
  a_poll: assert property (p_poll) else $error("poll request lost");
  property p_ac; anticoll_req && !poll_req |=> auto_anticoll_go ^ target_frame_to_fifo; endproperty
  a_ac: assert property (p_ac) else $error("anticollision request lost");
  property p_crc; reqa_wupa_sent |=> !crc_check_en; endproperty
  a_crc: assert property (p_crc) else $error("crc check after reqa");
  property p_fon; field_on_cmd ##1 !field_on_cmd |-> field_on_go ##1 !field_on_go; endproperty
  a_fon: assert property (p_fon) else $error("field on pulse wrong");
  c_go: cover property (poll_req ##1 auto_poll_reply_go);
  c_fifo: cover property (target_frame_to_fifo);
  c_err: cover property (pready && pslverr);
endmodule : npo_chk
`default_nettype wire

// ===== nfc_protocol_option_regs_test.sv
`include "npo_cfg.svh"
`default_nettype none
module nfc_protocol_option_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, ce_nfca, anticoll_bit, err;
  logic pready, pslverr, fdt_expire, auto_anticoll_go, auto_poll_reply_go, target_frame_to_fifo;
  logic target_via_fifo, crc_check_en, phase_clock_shift, rx_use_pulse, rx_sel_na, field_on_go;
  logic subcarrier_tick, report_tick, tx_period_tick, cfg_reserved_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] proto_mode, nfcid1_bytes;
  logic [11:0] fdt_nominal;
  logic [1:0] field_on_n;
  logic [5:0] ev;
  int mismatches, check_count, cyc, n;
  wire [2:0] ticks = {tx_period_tick, report_tick, subcarrier_tick};

  npo_option_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .proto_mode(proto_mode), .ce_nfca(ce_nfca), .fdt_start(ev[5]), .fdt_nominal(fdt_nominal),
    .anticoll_req(ev[1]), .poll_req(ev[0]), .reqa_wupa_sent(ev[2]), .anticoll_bit(anticoll_bit),
    .rx_end(ev[3]), .field_on_cmd(ev[4]), .fdt_expire(fdt_expire), .auto_anticoll_go(auto_anticoll_go),
    .auto_poll_reply_go(auto_poll_reply_go), .target_frame_to_fifo(target_frame_to_fifo),
    .target_via_fifo(target_via_fifo), .crc_check_en(crc_check_en), .nfcid1_bytes(nfcid1_bytes),
    .phase_clock_shift(phase_clock_shift), .rx_use_pulse(rx_use_pulse), .subcarrier_tick(subcarrier_tick),
    .report_tick(report_tick), .tx_period_tick(tx_period_tick), .cfg_reserved_err(cfg_reserved_err),
    .rx_sel_na(rx_sel_na), .field_on_go(field_on_go), .field_on_n(field_on_n));

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // hold keeps psel up so the next setup follows the access at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic hold);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!hold) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 6'h00;
    @(posedge pclk);
  endtask : pulse

  task automatic wt();
    repeat (2) @(posedge pclk);
  endtask : wt

  // the first two gaps may straddle a setting change, only the third counts
  task automatic per(input int s);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (ticks[s] !== 1'b1);
    end
  endtask : per

  task automatic t_regs();
    logic [7:0] a[3] = '{`NPO_ADDR_PTO, `NPO_ADDR_SMO, `NPO_ADDR_AUX};
    logic [7:0] m[3] = '{8'hf5, 8'h7f, 8'hbf};
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, a[i], 32'h0, 1'b0);
      chk("reset value", rd, 32'h0);
      apb(1'b1, a[i], 32'hffffffff, 1'b1);
      apb(1'b0, a[i], 32'h0, 1'b0);
      chk("readback", rd, {24'h0, m[i]});
      apb(1'b1, a[i], 32'h0, 1'b0);
    end
    apb(1'b1, 8'h2c, 32'hff, 1'b1);
    chk("unmapped err", err, 1'b1);
    apb(1'b0, 8'h2c, 32'h0, 1'b0);
    chk("unmapped read", {rd[31:1], err}, 32'h1);
  endtask : t_regs

  task automatic t_auto();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `NPO_ADDR_PTO, {29'h0, i[1], 1'b0, i[0]}, 1'b0);
      pulse(6'h01);
      chk("poll go", auto_poll_reply_go, !i[1]);
      chk("poll fifo", target_frame_to_fifo, i[1]);
      pulse(6'h02);
      chk("ac go", auto_anticoll_go, !i[0]);
      chk("ac fifo", target_frame_to_fifo, i[0]);
      chk("via fifo", target_via_fifo, i[1] | i[0]);
    end
  endtask : t_auto

  task automatic t_fdt();
    for (int i = 0; i < 2; i++) begin
      ce_nfca <= i[0];
      fdt_nominal <= 12'd20;
      apb(1'b1, `NPO_ADDR_PTO, 32'h20, 1'b0);
      ev <= 6'h20;
      @(posedge pclk);
      ev <= 6'h00;
      n = 0;
      while (fdt_expire !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk("fdt edges", n, 21 - 2 * i);
      @(posedge pclk);
    end
  endtask : t_fdt

  task automatic t_stream();
    proto_mode <= npo_pkg::NPO_MODE_STREAM_SUB;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `NPO_ADDR_SMO, {25'h0, i[1:0], 2'b11, 1'b0, i[1:0]}, 1'b0);
      per(0);
      chk("sub period", n, 64 >> i);
      per(2);
      chk("tx period", n, 128 >> i);
    end
    per(1);
    chk("report period", n, 64);
    chk("no reserved", cfg_reserved_err, 1'b0);
    apb(1'b1, `NPO_ADDR_SMO, 32'h1c, 1'b0);
    wt();
    chk("tx reserved", cfg_reserved_err, 1'b1);
    proto_mode <= npo_pkg::NPO_MODE_STREAM_BPSK;
    apb(1'b1, `NPO_ADDR_SMO, 32'h0, 1'b0);
    per(0);
    chk("bpsk period", n, 16);
    per(1);
    chk("bpsk report", n, 16);
    apb(1'b1, `NPO_ADDR_SMO, 32'h20, 1'b0);
    wt();
    chk("bpsk reserved", cfg_reserved_err, 1'b1);
  endtask : t_stream

  task automatic t_aux();
    logic [2:0] md[8] = '{3'd0, 3'd0, 3'd1, 3'd2, 3'd3, 3'd3, 3'd3, 3'd5};
    logic [7:0] sm[8] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h38, 8'h38, 8'h18, 8'h0};
    logic [7:0] pu = 8'b10101110;
    logic [7:0] na = 8'b01001010;
    logic [7:0] up = 8'b10100100;
    apb(1'b1, `NPO_ADDR_AUX, 32'h80, 1'b0);
    wt();
    chk("crc skip", crc_check_en, 1'b0);
    chk("shift off", phase_clock_shift, 1'b0);
    apb(1'b1, `NPO_ADDR_AUX, 32'h1a, 1'b0);
    wt();
    chk("crc on", crc_check_en, 1'b1);
    chk("id bytes", nfcid1_bytes, 3'd7);
    chk("shift", phase_clock_shift, 1'b1);
    pulse(6'h04);
    wt();
    chk("crc reqa", crc_check_en, 1'b0);
    pulse(6'h08);
    wt();
    chk("crc rx end", crc_check_en, 1'b1);
    anticoll_bit <= 1'b1;
    wt();
    chk("crc anticoll", crc_check_en, 1'b0);
    anticoll_bit <= 1'b0;
    pulse(6'h10);
    chk("field on", field_on_go, 1'b1);
    chk("field n", field_on_n, 2'd2);
    for (int i = 0; i < 8; i++) begin
      proto_mode <= md[i];
      apb(1'b1, `NPO_ADDR_SMO, {24'h0, sm[i]}, 1'b0);
      apb(1'b1, `NPO_ADDR_AUX, {29'h0, pu[i], 2'b00}, 1'b0);
      wt();
      chk("rx na", rx_sel_na, na[i]);
      if (!na[i]) chk("rx pulse", rx_use_pulse, up[i]);
    end
  endtask : t_aux

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // bounds a hung wait; the full run needs far fewer cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ev = 6'h00;
    proto_mode = 3'd0;
    ce_nfca = 1'b0;
    fdt_nominal = 12'h000;
    anticoll_bit = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("crc reset", crc_check_en, 1'b1);
    chk("id reset", nfcid1_bytes, 3'd4);
    t_regs();
    t_auto();
    t_fdt();
    t_stream();
    t_aux();
    end_sim();
  end
endmodule : nfc_protocol_option_regs_test

bind npo_option_regs npo_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .poll_req(poll_req),
  .anticoll_req(anticoll_req), .reqa_wupa_sent(reqa_wupa_sent), .field_on_cmd(field_on_cmd),
  .auto_poll_reply_go(auto_poll_reply_go), .auto_anticoll_go(auto_anticoll_go),
  .target_frame_to_fifo(target_frame_to_fifo), .crc_check_en(crc_check_en), .field_on_go(field_on_go));
`default_nettype wire
